//--- core/emac_pkg.sv
// constants and the nibble carrier type for the small ethernet mac
package emac_pkg;
  localparam int          EMAC_WB_W     = 32;
  localparam int          EMAC_PTR_W    = 11;
  localparam int          EMAC_FIFO_D   = 4;
  localparam logic [47:0] EMAC_STATION  = 48'h0;
  localparam logic [3:0]  EMAC_CTRL_OFF = 4'h0;
  localparam logic [3:0]  EMAC_DATA_OFF = 4'h4;
  localparam logic [3:0]  EMAC_ADDR_OFF = 4'h8;
  localparam int          EMAC_B_TXPTR  = 0;
  localparam int          EMAC_B_RXEN   = 1;
  localparam int          EMAC_B_TXGO   = 2;
  localparam int          EMAC_B_MACPTR = 3;
  localparam int          EMAC_B_RXDONE = 4;
  localparam int          EMAC_B_RXIE   = 5;
  localparam int          EMAC_B_TXIE   = 6;
  localparam int          EMAC_B_PROM   = 7;
  localparam logic [2:0]  EMAC_DA_BYTES = 3'h6;
  localparam logic [7:0]  EMAC_BCAST    = 8'hff;
  localparam logic [31:0] EMAC_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] EMAC_CRC_POLY = 32'hedb88320;
  localparam logic [31:0] EMAC_CRC_RES  = 32'hdebb20e3;
  localparam logic [3:0]  EMAC_PRE_NIB  = 4'h5;
  localparam logic [3:0]  EMAC_SFD_NIB  = 4'hd;
  localparam int          EMAC_PRE_LEN  = 16;
  localparam int          EMAC_FCS_NIBS = 8;

  // one nibble of the link with its strobes
  typedef struct packed {
    logic       valid;
    logic       error;
    logic [3:0] data;
  } emac_nib_t;
endpackage : emac_pkg

//--- core/emac_top.sv
// small 10 mbit ethernet mac: bus slave, tx fifo, rx and tx link logic

// fifo; depth must be a power of two
module emac_fifo #(
  parameter int W = 8,
  parameter int D = emac_pkg::EMAC_FIFO_D
) (
  input  wire logic         mclk_in,
  input  wire logic         nrst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   n;
  } emac_fifo_t;
  emac_fifo_t   f_reg, f_next;
  logic [W-1:0] mem [D];
  logic         push, pop;

  // honest full and empty from the fill count
  assign in_ready_out  = f_reg.n != (AW+1)'(D);
  assign out_valid_out = f_reg.n != '0;
  assign out_data_out  = mem[f_reg.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_comb begin
    f_next    = f_reg;
    f_next.wp = f_reg.wp + AW'(push);
    f_next.rp = f_reg.rp + AW'(pop);
    f_next.n  = f_reg.n + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) f_reg <= '0;
    else f_reg <= f_next;
  end

  // storage needs no reset
  always_ff @(posedge mclk_in) begin
    if (push) mem[f_reg.wp] <= in_data_in;
  end
endmodule : emac_fifo

module emac_top #(
  parameter int          WB_W    = emac_pkg::EMAC_WB_W,
  parameter int          ADDR_W  = emac_pkg::EMAC_WB_W,
  parameter int          PTR_W   = emac_pkg::EMAC_PTR_W,
  parameter logic [47:0] STATION = emac_pkg::EMAC_STATION
) (
  input  wire logic              mclk_in,
  input  wire logic              nrst_in,
  input  wire logic [ADDR_W-1:0] wb_adr_in,
  input  wire logic [WB_W-1:0]   wb_dat_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic              wb_we_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  output logic [WB_W-1:0]        wb_dat_out,
  output logic                   wb_ack_out,
  output logic                   wb_err_out,
  output logic                   irq_out,
  input  wire logic              rx_clk_in,
  input  wire logic [3:0]        rx_data_in,
  input  wire logic              rx_valid_in,
  input  wire logic              rx_error_in,
  input  wire logic              tx_clk_in,
  output logic [3:0]             tx_data_out,
  output logic                   tx_en_out,
  output logic                   tx_error_out
);
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_HOLD} emac_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_DATA, TX_FCS} emac_tx_st_t;
  typedef struct packed {
    logic             ack;
    logic             err;
    logic [WB_W-1:0]  dat;
    logic [PTR_W-1:0] txptr;
    logic [PTR_W-1:0] rdptr;
    logic [2:0]       macptr;
    logic             rxen;
    logic             rxie;
    logic             txie;
    logic             prom;
    logic             busy;
    logic             txev;
    logic             wait_f;
    logic             crcerr;
    logic [PTR_W:0]   rxlen;
    logic             go_t;
    logic             rel_t;
    logic [2:0]       rxd_sy;
    logic [2:0]       txd_sy;
    logic             irq;
  } emac_bus_t;
  typedef struct packed {
    emac_pkg::emac_nib_t pin;
    logic [1:0]          en_sy;
    logic [1:0]          pr_sy;
    logic [2:0]          rel_sy;
    emac_rx_st_t         st;
    logic                hi;
    logic [3:0]          lo;
    logic [PTR_W:0]      cnt;
    logic [31:0]         crc;
    logic                own;
    logic                bc;
    logic                bad;
    logic                crcerr;
    logic                done_t;
  } emac_rx_t;
  typedef struct packed {
    logic [2:0]          go_sy;
    emac_tx_st_t         st;
    logic                hi;
    logic [PTR_W:0]      cnt;
    logic [31:0]         crc;
    logic                done_t;
    emac_pkg::emac_nib_t pin;
  } emac_tx_t;

  emac_bus_t  b_reg, b_next;
  emac_rx_t   r_reg, r_next;
  emac_tx_t   t_reg, t_next;
  logic [7:0] tx_mem [2**PTR_W];
  logic [7:0] rx_mem [2**PTR_W];
  logic [1:0] rx_rst_sy, tx_rst_sy;
  logic       req, wr_ctrl, f_valid, f_ready, f_out_valid, drain;
  logic [7:0] f_out, rx_byte, tx_byte;
  logic       rx_we;
  logic [31:0] ctrl_rd;

  // full-width decode keeps aliases off the map
  function automatic logic emac_hit(logic [ADDR_W-1:0] a, logic [3:0] o);
    return (a[ADDR_W-1:4] == '0) && (a[3:0] == o);
  endfunction : emac_hit

  // station byte by index, lowest byte first
  function automatic logic [7:0] emac_sta(logic [2:0] i);
    return (i < emac_pkg::EMAC_DA_BYTES) ? STATION[{i, 3'h0} +: 8]
                                         : 8'h00;
  endfunction : emac_sta

  // reflected crc over one byte, lsb first
  function automatic logic [31:0] emac_crc8(logic [31:0] c, logic [7:0] d);
    logic [31:0] x;
    x = c;
    for (int i = 0; i < 8; i++) begin
      x = (x >> 1) ^ (emac_pkg::EMAC_CRC_POLY & {32{x[0] ^ d[i]}});
    end
    return x;
  endfunction : emac_crc8

  // link resets: async assert, release on the link clock
  always_ff @(posedge rx_clk_in or negedge nrst_in) begin
    if (!nrst_in) rx_rst_sy <= 2'h0;
    else rx_rst_sy <= {rx_rst_sy[0], 1'b1};
  end
  always_ff @(posedge tx_clk_in or negedge nrst_in) begin
    if (!nrst_in) tx_rst_sy <= 2'h0;
    else tx_rst_sy <= {tx_rst_sy[0], 1'b1};
  end

  // data writes wait here; a full fifo holds off the ack
  emac_fifo #(.W(8), .D(emac_pkg::EMAC_FIFO_D)) u_txf (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (f_valid),
    .in_ready_out  (f_ready),
    .in_data_in    (wb_dat_in[7:0]),
    .out_valid_out (f_out_valid),
    .out_ready_in  (~b_reg.busy),
    .out_data_out  (f_out)
  );

  // control/status read image
  assign ctrl_rd = {16'(b_reg.rxlen), 6'h00,
                    b_reg.crcerr & b_reg.wait_f,
                    b_reg.wait_f, b_reg.prom, b_reg.txie, b_reg.rxie,
                    2'h0, b_reg.busy, b_reg.rxen, 1'b0};
  assign req     = wb_cyc_in & wb_stb_in & ~b_reg.ack & ~b_reg.err;
  assign wr_ctrl = req & wb_we_in & wb_sel_in[0]
                 & emac_hit(wb_adr_in, emac_pkg::EMAC_CTRL_OFF);
  assign f_valid = req & wb_we_in
                 & emac_hit(wb_adr_in, emac_pkg::EMAC_DATA_OFF);
  // buffer only fills while no frame is going out
  assign drain   = f_out_valid & ~b_reg.busy;

  // bus side next state
  always_comb begin
    b_next        = b_reg;
    b_next.ack    = 1'b0;
    b_next.err    = 1'b0;
    b_next.rxd_sy = {b_reg.rxd_sy[1:0], r_reg.done_t};
    b_next.txd_sy = {b_reg.txd_sy[1:0], t_reg.done_t};
    if (req) begin
      if (emac_hit(wb_adr_in, emac_pkg::EMAC_CTRL_OFF)) begin
        b_next.ack = 1'b1;
        b_next.dat = WB_W'(ctrl_rd);
      end else if (emac_hit(wb_adr_in, emac_pkg::EMAC_DATA_OFF)) begin
        b_next.ack = wb_we_in ? f_ready : 1'b1;
        if (!wb_we_in) begin
          b_next.dat   = WB_W'(rx_mem[b_reg.rdptr]);
          b_next.rdptr = b_reg.rdptr + 1'b1;
        end
      end else if (emac_hit(wb_adr_in, emac_pkg::EMAC_ADDR_OFF)) begin
        b_next.ack    = 1'b1;
        b_next.dat    = WB_W'(emac_sta(b_reg.macptr));
        b_next.macptr = b_reg.macptr + 1'b1;
      end else begin
        b_next.err = 1'b1;
      end
    end
    if (drain) b_next.txptr = b_reg.txptr + 1'b1;
    if (wr_ctrl) begin
      b_next.rxen = wb_dat_in[emac_pkg::EMAC_B_RXEN];
      b_next.rxie = wb_dat_in[emac_pkg::EMAC_B_RXIE];
      b_next.txie = wb_dat_in[emac_pkg::EMAC_B_TXIE];
      b_next.prom = wb_dat_in[emac_pkg::EMAC_B_PROM];
      b_next.txev = 1'b0;
      if (wb_dat_in[emac_pkg::EMAC_B_TXPTR]) b_next.txptr = '0;
      if (wb_dat_in[emac_pkg::EMAC_B_MACPTR]) b_next.macptr = '0;
      if (wb_dat_in[emac_pkg::EMAC_B_TXGO] && !b_reg.busy) begin
        b_next.go_t = ~b_reg.go_t;
        b_next.busy = 1'b1;
      end
      if (wb_dat_in[emac_pkg::EMAC_B_RXDONE] && b_reg.wait_f) begin
        b_next.rel_t  = ~b_reg.rel_t;
        b_next.wait_f = 1'b0;
        b_next.rdptr  = '0;
      end
    end
    // link events after the write, so a set beats a clear
    if (b_reg.txd_sy[2] ^ b_reg.txd_sy[1]) begin
      b_next.busy = 1'b0;
      b_next.txev = 1'b1;
    end
    if (b_reg.rxd_sy[2] ^ b_reg.rxd_sy[1]) begin
      b_next.wait_f = 1'b1;
      b_next.rxlen  = r_reg.cnt; // held still while rx waits
      b_next.crcerr = r_reg.crcerr;
    end
    b_next.irq = (b_next.wait_f & b_next.rxie)
               | (b_next.txev & b_next.txie);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) b_reg <= '0;
    else b_reg <= b_next;
  end
  always_ff @(posedge mclk_in) begin
    if (drain) tx_mem[b_reg.txptr] <= f_out;
  end

  assign wb_dat_out = b_reg.dat;
  assign wb_ack_out = b_reg.ack;
  assign wb_err_out = b_reg.err;
  assign irq_out    = b_reg.irq;

  // receive side; pins are synchronous to rx_clk_in
  assign rx_byte = {r_reg.pin.data, r_reg.lo};
  always_comb begin
    r_next        = r_reg;
    rx_we         = 1'b0;
    r_next.pin    = {rx_valid_in, rx_error_in, rx_data_in};
    r_next.en_sy  = {r_reg.en_sy[0], b_reg.rxen};
    r_next.pr_sy  = {r_reg.pr_sy[0], b_reg.prom};
    r_next.rel_sy = {r_reg.rel_sy[1:0], b_reg.rel_t};
    unique case (r_reg.st)
      RX_IDLE: begin
        if (r_reg.pin.valid && r_reg.en_sy[1]
            && r_reg.pin.data == emac_pkg::EMAC_SFD_NIB) begin
          r_next.st  = RX_DATA;
          r_next.cnt = '0;
          r_next.hi  = 1'b0;
          r_next.crc = emac_pkg::EMAC_CRC_INIT;
          r_next.own = 1'b1;
          r_next.bc  = 1'b1;
          r_next.bad = 1'b0;
        end
      end
      RX_DATA: begin
        if (r_reg.pin.valid) begin
          r_next.bad = r_reg.bad | r_reg.pin.error;
          r_next.hi  = ~r_reg.hi;
          r_next.lo  = r_reg.pin.data;
          if (r_reg.hi) begin
            r_next.crc = emac_crc8(r_reg.crc, rx_byte);
            if (r_reg.cnt < (PTR_W+1)'(emac_pkg::EMAC_DA_BYTES)) begin
              r_next.own = r_reg.own
                         & (rx_byte == emac_sta(r_reg.cnt[2:0]));
              r_next.bc  = r_reg.bc & (rx_byte == emac_pkg::EMAC_BCAST);
            end
            rx_we = ~r_reg.cnt[PTR_W]; // overflow bytes are dropped
            if (!(&r_reg.cnt)) r_next.cnt = r_reg.cnt + 1'b1;
          end
        end else if (r_reg.cnt != '0
                     && (r_reg.pr_sy[1] | r_reg.own | r_reg.bc)) begin
          r_next.st     = RX_HOLD;
          r_next.done_t = ~r_reg.done_t;
          r_next.crcerr = r_reg.bad | r_reg.hi
                        | (r_reg.crc != emac_pkg::EMAC_CRC_RES);
        end else begin
          r_next.st = RX_IDLE;
        end
      end
      RX_HOLD: begin
        if (r_reg.rel_sy[2] ^ r_reg.rel_sy[1]) r_next.st = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge rx_clk_in or negedge rx_rst_sy[1]) begin
    if (!rx_rst_sy[1]) r_reg <= '0;
    else r_reg <= r_next;
  end
  always_ff @(posedge rx_clk_in) begin
    if (rx_we) rx_mem[r_reg.cnt[PTR_W-1:0]] <= rx_byte;
  end

  // transmit side; buffer stays still while busy, length too unless a control write clears txptr
  assign tx_byte = tx_mem[t_reg.cnt[PTR_W-1:0]];
  always_comb begin
    t_next       = t_reg;
    t_next.go_sy = {t_reg.go_sy[1:0], b_reg.go_t};
    t_next.pin   = '0;
    unique case (t_reg.st)
      TX_IDLE: begin
        if (t_reg.go_sy[2] ^ t_reg.go_sy[1]) begin
          t_next.st  = TX_PRE;
          t_next.cnt = '0;
          t_next.crc = emac_pkg::EMAC_CRC_INIT;
        end
      end
      TX_PRE: begin
        t_next.pin = {2'b10, emac_pkg::EMAC_PRE_NIB};
        t_next.cnt = t_reg.cnt + 1'b1;
        if (t_reg.cnt == (PTR_W+1)'(emac_pkg::EMAC_PRE_LEN - 1)) begin
          t_next.pin.data = emac_pkg::EMAC_SFD_NIB;
          t_next.cnt = '0;
          t_next.hi  = 1'b0;
          t_next.st  = (b_reg.txptr == '0) ? TX_FCS : TX_DATA;
        end
      end
      TX_DATA: begin
        t_next.pin = {2'b10, t_reg.hi ? tx_byte[7:4] : tx_byte[3:0]};
        t_next.hi  = ~t_reg.hi;
        if (t_reg.hi) begin
          t_next.crc = emac_crc8(t_reg.crc, tx_byte);
          t_next.cnt = t_reg.cnt + 1'b1;
          if (t_next.cnt == {1'b0, b_reg.txptr}) begin
            t_next.cnt = '0;
            t_next.st  = TX_FCS;
          end
        end
      end
      TX_FCS: begin
        t_next.pin = {2'b10, ~t_reg.crc[3:0]};
        t_next.crc = {4'h0, t_reg.crc[31:4]};
        t_next.cnt = t_reg.cnt + 1'b1;
        if (t_reg.cnt == (PTR_W+1)'(emac_pkg::EMAC_FCS_NIBS - 1)) begin
          t_next.st     = TX_IDLE;
          t_next.done_t = ~t_reg.done_t;
        end
      end
    endcase
  end

  always_ff @(posedge tx_clk_in or negedge tx_rst_sy[1]) begin
    if (!tx_rst_sy[1]) t_reg <= '0;
    else t_reg <= t_next;
  end

  assign tx_data_out  = t_reg.pin.data;
  assign tx_en_out    = t_reg.pin.valid;
  assign tx_error_out = t_reg.pin.error;

  // checks on the bus side
  a_wb_answer: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    req && !f_valid |=> wb_ack_out ^ wb_err_out)
    else $error("bus cycle not answered");
  a_unmapped_err: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    req && wb_adr_in[3:0] == 4'hc |=> wb_err_out && !wb_ack_out)
    else $error("unmapped access not refused");
  a_go_sets_busy: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_ctrl && wb_dat_in[2] && !b_reg.busy
    |=> b_reg.busy && b_reg.go_t != $past(b_reg.go_t))
    else $error("start did not raise busy");
  a_txptr_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_ctrl && wb_dat_in[0] |=> b_reg.txptr == '0)
    else $error("tx pointer not cleared");
  a_macptr_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_ctrl && wb_dat_in[3] |=> b_reg.macptr == 3'h0)
    else $error("station pointer not cleared");
  a_release_frees: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wr_ctrl && wb_dat_in[4] && b_reg.wait_f
    |=> !b_reg.wait_f ##2 r_reg.rel_sy[0] == b_reg.rel_t)
    else $error("release not passed on");
  a_rx_irq: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    b_reg.wait_f && b_reg.rxie |-> irq_out)
    else $error("rx interrupt missing");
  a_tx_irq: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $rose(b_reg.txev) && b_reg.txie |-> irq_out && !b_reg.busy)
    else $error("tx interrupt missing");
  a_crc_when_wait: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    wb_ack_out && wb_dat_out[9] |-> wb_dat_out[8])
    else $error("crc flag without waiting frame");

  // checks on the link sides
  a_rx_enable: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_sy[1])
    r_reg.st == RX_IDLE && !r_reg.en_sy[1] |=> r_reg.st == RX_IDLE)
    else $error("frame taken while disabled");
  a_rx_filter: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_sy[1])
    r_reg.st == RX_DATA && !r_reg.pin.valid && !r_reg.pr_sy[1]
    && !r_reg.own && !r_reg.bc |=> r_reg.st == RX_IDLE)
    else $error("foreign frame kept");
  a_rx_hold: assert property (@(posedge rx_clk_in) disable iff (!rx_rst_sy[1])
    r_reg.st == RX_HOLD && !(r_reg.rel_sy[2] ^ r_reg.rel_sy[1])
    |=> r_reg.st == RX_HOLD)
    else $error("buffer left before release");
  a_tx_preamble: assert property (@(posedge tx_clk_in) disable iff (!tx_rst_sy[1])
    t_reg.st == TX_PRE && t_reg.cnt == '0
    |=> tx_en_out && tx_data_out == emac_pkg::EMAC_PRE_NIB)
    else $error("preamble not driven");
endmodule : emac_top

//--- sim/emac_phy.sv
// phy model: free running link clocks, frame sender, transmit capture
module emac_phy (
  output logic            rx_clk_out,
  output logic [3:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            rx_error_out,
  output logic            tx_clk_out,
  input  wire logic [3:0] tx_data_in,
  input  wire logic       tx_en_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_q[$];
  logic [3:0] lo;
  logic       sfd, half;
  int         pre, pre_n;

  // both link clocks run at 32 ns, offset so no edge lines up
  initial begin
    rx_clk_out = 1'b0;
    forever #16 rx_clk_out = ~rx_clk_out;
  end
  initial begin
    tx_clk_out = 1'b0;
    #7;
    forever #16 tx_clk_out = ~tx_clk_out;
  end
  initial begin
    rx_valid_out = 1'b0;
    rx_error_out = 1'b0;
    rx_data_out  = 4'h0;
  end

  // fcs of a byte list, reflected, already inverted for the wire
  function automatic logic [31:0] crc(input logic [7:0] b[$]);
    logic [31:0] c;
    c = emac_pkg::EMAC_CRC_INIT;
    foreach (b[i])
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? emac_pkg::EMAC_CRC_POLY : 32'h0);
    return ~c;
  endfunction : crc

  // nibble on the falling edge; idle data keeps moving, never stale
  task automatic nib(input logic [3:0] d, input logic v);
    @(negedge rx_clk_out);
    rx_data_out  <= v ? d : rx_data_out + 4'h7;
    rx_valid_out <= v;
  endtask

  // preamble, delimiter, bytes low nibble first, fcs, gap
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [31:0] f;
    f = crc(b) ^ {31'h0, bad}; // one fcs bit broken on request
    for (int i = 0; i < 4; i++)
      b.push_back(f[8*i +: 8]);
    repeat (15) nib(emac_pkg::EMAC_PRE_NIB, 1'b1);
    nib(emac_pkg::EMAC_SFD_NIB, 1'b1);
    foreach (b[i]) begin
      nib(b[i][3:0], 1'b1);
      nib(b[i][7:4], 1'b1);
    end
    repeat (12) nib(4'h0, 1'b0);
  endtask

  // collect sent bytes after the delimiter, count preamble nibbles
  always @(posedge tx_clk_out) begin
    if (!tx_en_in) begin
      sfd  <= 1'b0;
      half <= 1'b0;
      pre  <= 0;
    end else if (!sfd) begin
      if (tx_data_in == emac_pkg::EMAC_SFD_NIB) begin
        sfd   <= 1'b1;
        pre_n <= pre;
        tx_q.delete();
      end else if (tx_data_in == emac_pkg::EMAC_PRE_NIB) pre <= pre + 1;
    end else if (!half) begin
      lo   <= tx_data_in;
      half <= 1'b1;
    end else begin
      tx_q.push_back({tx_data_in, lo});
      half <= 1'b0;
    end
  end
endmodule : emac_phy

//--- sim/emac_top_tb.sv
// self-checking bench for the small ethernet mac
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); \
  end \
end

module emac_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [47:0] STN = 48'h665544332211;
  localparam logic [5:0]  TC [5] = '{6'h21, 6'h24, 6'h35, 6'h2b, 6'h00};
  typedef struct packed {
    logic        e;
    logic [31:0] m;
    logic [31:0] v;
  } emac_note_t;
  logic        mclk, nrst, we, cyc, stb, ack, err, irq;
  logic [31:0] adr, wdat, rdat;
  logic        rxc, rxv, rxe, txc, txen, txer;
  logic [3:0]  rxd, txd;
  logic [7:0]  cfg;
  int          fails, total_checks;
  emac_note_t  notes[$];
  logic [7:0]  q[$];

  emac_top #(.STATION(STN)) u_emac_top (
    .mclk_in(mclk), .nrst_in(nrst), .wb_adr_in(adr), .wb_dat_in(wdat),
    .wb_sel_in(4'hf), .wb_we_in(we), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err),
    .irq_out(irq), .rx_clk_in(rxc), .rx_data_in(rxd),
    .rx_valid_in(rxv), .rx_error_in(rxe), .tx_clk_in(txc),
    .tx_data_out(txd), .tx_en_out(txen), .tx_error_out(txer));
  emac_phy u_emac_phy (
    .rx_clk_out(rxc), .rx_data_out(rxd), .rx_valid_out(rxv),
    .rx_error_out(rxe), .tx_clk_out(txc), .tx_data_in(txd),
    .tx_en_in(txen));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // each bus answer is compared with the oldest note
  always @(posedge mclk) begin
    if (ack | err) begin
      if (notes.size() == 0) fails++;
      else begin
        `CHK(err, notes[0].e)
        `CHK(rdat & notes[0].m, notes[0].v)
        void'(notes.pop_front());
      end
    end
  end

  // request held from a falling edge until the falling edge after the answer
  task automatic wb(input logic [31:0] a, input logic w,
                    input logic [31:0] d, input emac_note_t nt,
                    output logic [31:0] r);
    int k;
    notes.push_back(nt);
    @(negedge mclk);
    adr  <= a;
    wdat <= d;
    we   <= w;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (!(ack | err) && k < 40);
    if (k == 40) fails++;
    r = rdat;
    @(negedge mclk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, m, v);
    logic [31:0] r;
    wb(a, 1'b0, 32'h0, '{1'b0, m, v}, r);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    wb(a, 1'b1, d, '0, r);
  endtask

  // destination (broadcast, own, or other) then random payload
  function automatic void mk(input int kind);
    q = {};
    for (int i = 0; i < 6; i++)
      q.push_back(kind == 0 ? 8'hff : STN[8*i +: 8] ^ {7'h0, kind == 2});
    repeat (8) q.push_back(8'($urandom));
  endfunction

  task automatic finish_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // a hang is cut short well after the whole run should have ended
  initial begin
    #200us;
    fails++;
    finish_test();
  end

  initial begin
    logic [31:0] r, f;
    int k;
    {nrst, we, cyc, stb, adr, wdat} = '0;
    void'($urandom(86897));
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    rd(32'h0, 32'hffffffff, 32'h0);
    foreach (TC[i]) begin
      k = i;
      r = k == 0 ? 32'hc : (k == 1 ? 32'h10 : 32'h80000000);
      if (k < 3) wb(r, k[0], 32'h0, '{1'b1, 32'h0, 32'h0}, f);
    end
    // station bytes lowest first; pointer restarts on bit 3
    wr(32'h0, 32'h8);
    for (int i = 0; i < 8; i++) begin
      if (i == 2) wr(32'h0, 32'h8);
      rd(32'h8, 32'hff, {24'h0, STN[8*(i < 2 ? i : i - 2) +: 8]});
    end
    // broadcast frame waits, a second one is refused, then release
    cfg = 8'h22;
    wr(32'h0, {24'h0, cfg});
    mk(0);
    u_emac_phy.send(q, 1'b0);
    `CHK(irq, 1'b1)
    rd(32'h0, 32'hffffffff, {16'd18, 8'h01, cfg});
    for (int i = 0; i < 3; i++) rd(32'h4, 32'hff, {24'h0, q[i]});
    mk(0);
    u_emac_phy.send(q, 1'b0);
    rd(32'h0, 32'hffff0000, {16'd18, 16'h0});
    wr(32'h0, {24'h0, cfg | 8'h10});
    rd(32'h0, 32'h100, 32'h0);
    `CHK(irq, 1'b0)
    // filter table: enable, promisc, bad fcs, other address -> crc, taken
    foreach (TC[i]) begin
      cfg = {TC[i][4], 5'h0, TC[i][5], 1'b0};
      wr(32'h0, {24'h0, cfg});
      mk(TC[i][2] ? 2 : 1);
      u_emac_phy.send(q, TC[i][3]);
      rd(32'h0, 32'h300, {22'h0, TC[i][1:0], 8'h0});
      wr(32'h0, 32'h10);
    end
    // stale bytes dropped by pointer reset, frame and fcs on the link
    cfg = 8'h40;
    wr(32'h0, {24'h0, cfg});
    repeat (3) wr(32'h4, 32'hee);
    wr(32'h0, {24'h0, cfg | 8'h01});
    q = {};
    repeat (5) q.push_back(8'($urandom));
    foreach (q[i]) wr(32'h4, {24'h0, q[i]});
    repeat (8) @(posedge mclk);
    wr(32'h0, {24'h0, cfg | 8'h04});
    rd(32'h0, 32'h4, 32'h4);
    k = 0;
    do begin
      wb(32'h0, 1'b0, 32'h0, '0, r);
      k++;
    end while (r[2] !== 1'b0 && k < 100);
    // busy that never falls is a hang, not a pass
    if (k == 100) fails++;
    f = u_emac_phy.crc(q);
    for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8]);
    `CHK(u_emac_phy.pre_n, 15)
    `CHK(u_emac_phy.tx_q.size(), 9)
    foreach (q[i]) `CHK(u_emac_phy.tx_q[i], q[i])
    `CHK(irq, 1'b1)
    wr(32'h0, {24'h0, cfg});
    `CHK(irq, 1'b0)
    finish_test();
  end
endmodule : emac_top_tb
